// ==== tb_utopia_cell_port_phy_control.sv ====
// Purpose: self-checking bench for ucp_cell_port
// Assumes: inputs change at the falling edge, fixed seed
// Notes: expected rx bytes come from a bench function, tx bytes from a queue of sent bytes
module tb_utopia_cell_port_phy_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, handshakeLevelSelect = 0, externalPhySelect = 1, swReset = 0;
  logic rxReady = 0, txSoc = 0, txValid = 0, ctlReq = 0, ctlRead = 0, phyIrqN = 1;
  logic signalDetectIn = 0, slow = 0, room = 1;
  logic [7:0] txData = 8'h00;
  wire [7:0] rxByteBus, rxData_q, txByteBus_q;
  wire rxCellStart, rxEmptyAvail, rxAcceptN_q, rxLinkClock, rxValid_q, rxSoc_q;
  wire txCellStart_q, txValidN_q, txFullRoom, txLinkClock, txReady, phyCtlDirection_q;
  wire phyCtlDirectionOe, phyReadEnableN_q, phySelectN_q, phySelectOe, phyResetOutN_q;
  wire ctlBusy, ctlDone_q, phyIrqPending_q, signalDetect_q;
  integer seed = 60226, errCount = 0, nChecks = 0, rxCnt = 0, txCnt = 0, k, m, md;
  logic [8:0] txQ[$];
  initial forever #25 clk = ~clk;
  ucp_cell_port dut_u (
    .clk(clk), .rstn(rstn), .handshakeLevelSelect(handshakeLevelSelect),
    .externalPhySelect(externalPhySelect), .swReset(swReset), .rxByteBus(rxByteBus),
    .rxCellStart(rxCellStart), .rxEmptyAvail(rxEmptyAvail), .rxAcceptN_q(rxAcceptN_q),
    .rxLinkClock(rxLinkClock), .rxReady(rxReady), .rxData_q(rxData_q),
    .rxValid_q(rxValid_q), .rxSoc_q(rxSoc_q), .txByteBus_q(txByteBus_q),
    .txCellStart_q(txCellStart_q), .txValidN_q(txValidN_q), .txFullRoom(txFullRoom),
    .txLinkClock(txLinkClock), .txData(txData), .txSoc(txSoc), .txValid(txValid),
    .txReady(txReady), .phyCtlDirection_q(phyCtlDirection_q),
    .phyCtlDirectionOe(phyCtlDirectionOe), .phyReadEnableN_q(phyReadEnableN_q),
    .phySelectN_q(phySelectN_q), .phySelectOe(phySelectOe),
    .signalDetectIn(signalDetectIn), .phyIrqN(phyIrqN), .phyResetOutN_q(phyResetOutN_q),
    .ctlReq(ctlReq), .ctlRead(ctlRead), .ctlBusy(ctlBusy), .ctlDone_q(ctlDone_q),
    .phyIrqPending_q(phyIrqPending_q), .signalDetect_q(signalDetect_q));
  ucp_phy_model phy_u (.clk(clk), .rstn(rstn), .cellMode(handshakeLevelSelect),
    .slow(slow), .room(room), .rxAcceptN(rxAcceptN_q), .rxByte(rxByteBus),
    .rxSoc(rxCellStart), .rxEmptyAvail(rxEmptyAvail), .txFullRoom(txFullRoom));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic [7:0] expByte(input integer n);
    expByte = n[7:0] ^ 8'h5A;
  endfunction
  task automatic check(input [8:0] got, input [8:0] exp);
    nChecks = nChecks + 1;
    if (got !== exp) begin
      errCount = errCount + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stopTest;
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic sendTx(input integer cnt);
    for (m = 0; m < cnt; m = m + 1) begin
      @(negedge clk);
      txValid = 1;
      txSoc = (txCnt % 53 == 0);
      txData = $random(seed);
      room = ($random(seed) & 3) != 0;
      rxReady = ($random(seed) & 3) != 0;
      k = 0;
      #20;
      while (txReady !== 1'b1 && k < 200) begin
        @(negedge clk);
        room = 1;
        k = k + 1;
        #20;
      end
      @(posedge clk);
      txQ.push_back({txSoc, txData});
      txCnt = txCnt + 1;
    end
    @(negedge clk);
    txValid = 0;
  endtask
  task automatic ctl(input logic rd);
    logic [2:0] e;
    @(negedge clk);
    ctlReq = 1;
    ctlRead = rd;
    @(negedge clk);
    ctlReq = 0;
    e = externalPhySelect ? {2'b10, ~rd} : 3'b011;
    check({ctlBusy, phySelectN_q, phyReadEnableN_q}, e);
    check({phySelectOe, phyCtlDirectionOe}, {2{externalPhySelect}});
    if (externalPhySelect) check(phyCtlDirection_q, rd);
    for (k = 1; ctlDone_q !== 1'b1 && k < 20; k = k + 1) @(negedge clk);
    check(k, externalPhySelect ? 5 : 20);
  endtask
  // ----------------------------------------------------------
  // monitor and sequence
  // ----------------------------------------------------------
  always @(negedge clk) begin
    // let the forwarded clocks settle before comparing them with clk
    #1;
    check(rxLinkClock, clk);
    check(txLinkClock, clk);
    if (!rstn) rxCnt = 0;
    else if (rxValid_q === 1'b1) begin
      check(rxData_q, expByte(rxCnt));
      check(rxSoc_q, rxCnt % 53 == 0);
      rxCnt = rxCnt + 1;
    end
    if (rstn && txValidN_q === 1'b0)
      check({txCellStart_q, txByteBus_q}, txQ.size() ? txQ.pop_front() : 9'h1FF);
  end
  initial begin
    #3000000;
    errCount = errCount + 1;
    stopTest;
  end
  initial begin
    for (md = 0; md < 2; md = md + 1) begin
      @(negedge clk);
      rstn = 0;
      handshakeLevelSelect = md;
      slow = 1;
      txQ.delete();
      txCnt = 0;
      repeat (10) @(negedge clk);
      rstn = 1;
      @(negedge clk);
      check(phyResetOutN_q, 0);
      sendTx(53);
      if (md) check(rxCnt, 0);
      slow = 0;
      sendTx(106);
      repeat (200) @(negedge clk);
      check(rxCnt >= 53, 1);
    end
    ctl(1);
    ctl(0);
    @(negedge clk);
    swReset = 1;
    phyIrqN = 0;
    @(negedge clk);
    swReset = 0;
    for (k = 0; phyResetOutN_q === 1'b0 && k < 40; k = k + 1) @(negedge clk);
    check(k, 17);
    check(phyIrqPending_q, 1);
    phyIrqN = 1;
    repeat (5) @(negedge clk);
    check(phyIrqPending_q, 0);
    externalPhySelect = 0;
    signalDetectIn = 1;
    rxReady = 1;
    k = rxCnt;
    ctl(1);
    check(signalDetect_q, 1);
    check(rxCnt > k, 1);
    stopTest;
  end
endmodule
bind ucp_cell_port ucp_cell_port_properties chk_u (
  .clk(clk), .rstn(rstn), .handshakeLevelSelect(handshakeLevelSelect),
  .externalPhySelect(externalPhySelect), .swReset(swReset), .rxReady(rxReady),
  .rxAcceptN_q(rxAcceptN_q), .txValid(txValid), .txReady(txReady),
  .txValidN_q(txValidN_q), .txCellStart_q(txCellStart_q), .ctlReq(ctlReq),
  .ctlRead(ctlRead), .ctlBusy(ctlBusy), .phyCtlDirection_q(phyCtlDirection_q),
  .phyReadEnableN_q(phyReadEnableN_q), .phySelectN_q(phySelectN_q),
  .phySelectOe(phySelectOe), .phyIrqN(phyIrqN), .phyIrqPending_q(phyIrqPending_q),
  .phyResetOutN_q(phyResetOutN_q));

// ==== ucp_cell_port.v ====
// Purpose: ATM-layer end of an 8-bit cell interface plus PHY control port
// Assumes: clk 20 MHz, rstn synchronous active low, PHY pins sampled by two flops
// Notes: link clocks are forwarded copies of clk; pin latency is hidden by
//   tracking the accept history, so octet mode may overrun the PHY by a few bytes
`include "ucp_defines.vh"

module ucp_cell_port #(
  parameter CELL_BYTES = `UCP_CELL_BYTES,
  parameter PHY_RST_CYCLES = `UCP_PHY_RST_CYCLES,
  parameter CTL_ACCESS_CYCLES = `UCP_CTL_ACCESS_CYCLES
) (
  input wire clk,
  input wire rstn,
  // configuration
  input wire handshakeLevelSelect,
  input wire externalPhySelect,
  input wire swReset,
  // receive pins
  input wire [7:0] rxByteBus,
  input wire rxCellStart,
  input wire rxEmptyAvail,
  output reg rxAcceptN_q,
  output wire rxLinkClock,
  // receive user side
  input wire rxReady,
  output reg [7:0] rxData_q,
  output reg rxValid_q,
  output reg rxSoc_q,
  // transmit pins
  output reg [7:0] txByteBus_q,
  output reg txCellStart_q,
  output reg txValidN_q,
  input wire txFullRoom,
  output wire txLinkClock,
  // transmit user side
  input wire [7:0] txData,
  input wire txSoc,
  input wire txValid,
  output wire txReady,
  // phy control pins
  output reg phyCtlDirection_q,
  output wire phyCtlDirectionOe,
  output reg phyReadEnableN_q,
  output reg phySelectN_q,
  output wire phySelectOe,
  input wire signalDetectIn,
  input wire phyIrqN,
  output reg phyResetOutN_q,
  // phy control user side
  input wire ctlReq,
  input wire ctlRead,
  output wire ctlBusy,
  output reg ctlDone_q,
  output reg phyIrqPending_q,
  output reg signalDetect_q
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [7:0] rxByteSync;
  wire rxStartSync;
  wire rxAvailSync;
  wire txRoomSync;
  wire detectSync;
  wire irqNSync;

  ucp_sync #(
    .WIDTH(10),
    .RESET_VAL(10'h000)
  ) uRxSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn({rxEmptyAvail, rxCellStart, rxByteBus}),
    .syncOut({rxAvailSync, rxStartSync, rxByteSync})
  );

  ucp_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h2)
  ) uMiscSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn({txFullRoom, phyIrqN, signalDetectIn}),
    .syncOut({txRoomSync, irqNSync, detectSync})
  );

  // ---------------------------------------------------------------
  // link clocks
  // ---------------------------------------------------------------
  assign rxLinkClock = clk;
  assign txLinkClock = clk;

  // ---------------------------------------------------------------
  // receive side
  // ---------------------------------------------------------------
  // the pins reach the logic three edges after the accept that asked for them,
  // so the accept history is delayed to line up with the synchronised bus
  reg [`UCP_RX_LAT-1:0] acceptHist_q;
  reg [1:0] rxState_q;
  reg [1:0] rxState_d;
  reg [`UCP_CNT_W-1:0] rxCount_q;
  reg [`UCP_CNT_W-1:0] rxCount_d;
  reg rxAcceptN_d;
  wire rxAligned;
  wire rxByteOk;

  assign rxAligned = acceptHist_q[`UCP_RX_LAT-1];
  // octet mode needs the not-empty level, cell mode trusts the granted slots
  assign rxByteOk = handshakeLevelSelect ? rxAligned : (rxAligned & rxAvailSync);

  always @* begin
    rxState_d = rxState_q;
    rxCount_d = rxCount_q;
    rxAcceptN_d = 1'b1;
    if (handshakeLevelSelect) begin
      case (rxState_q)
        `UCP_RX_IDLE: begin
          if (rxAvailSync && rxReady) begin
            rxState_d = `UCP_RX_READ;
            rxCount_d = {`UCP_CNT_W{1'b0}};
            rxAcceptN_d = 1'b0;
          end
        end
        `UCP_RX_READ: begin
          if (rxCount_q == CELL_BYTES[`UCP_CNT_W-1:0] - 6'h01) begin
            rxState_d = `UCP_RX_DRAIN_ST;
            rxCount_d = {`UCP_CNT_W{1'b0}};
          end else begin
            rxCount_d = rxCount_q + 6'h01;
            rxAcceptN_d = 1'b0;
          end
        end
        `UCP_RX_DRAIN_ST: begin
          // wait until cell-available reflects the state after this cell
          if (rxCount_q == `UCP_RX_DRAIN - 1) begin
            rxState_d = `UCP_RX_IDLE;
          end else begin
            rxCount_d = rxCount_q + 6'h01;
          end
        end
        default: begin
          rxState_d = `UCP_RX_IDLE;
        end
      endcase
    end else begin
      rxState_d = `UCP_RX_IDLE;
      rxCount_d = {`UCP_CNT_W{1'b0}};
      rxAcceptN_d = ~rxReady;
    end
  end

  // receive logic is not gated by the phy mode, so an external fifo works too
  always @(posedge clk) begin
    if (!rstn) begin
      rxState_q <= `UCP_RX_IDLE;
      rxCount_q <= {`UCP_CNT_W{1'b0}};
      rxAcceptN_q <= 1'b1;
      acceptHist_q <= {`UCP_RX_LAT{1'b0}};
      rxData_q <= 8'h00;
      rxValid_q <= 1'b0;
      rxSoc_q <= 1'b0;
    end else begin
      rxState_q <= rxState_d;
      rxCount_q <= rxCount_d;
      rxAcceptN_q <= rxAcceptN_d;
      acceptHist_q <= {acceptHist_q[`UCP_RX_LAT-2:0], ~rxAcceptN_q};
      rxValid_q <= rxByteOk;
      if (rxByteOk) begin
        rxData_q <= rxByteSync;
        rxSoc_q <= rxStartSync;
      end else begin
        rxSoc_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit side
  // ---------------------------------------------------------------
  reg txState_q;
  reg txState_d;
  reg [`UCP_CNT_W-1:0] txCount_q;
  reg [`UCP_CNT_W-1:0] txCount_d;
  reg txOpen;
  wire txTake;

  // octet mode: full (low) stalls; cell mode: room checked only at cell start
  always @* begin
    txOpen = 1'b0;
    if (handshakeLevelSelect) begin
      txOpen = (txState_q == `UCP_TX_CELL) | txRoomSync;
    end else begin
      txOpen = txRoomSync;
    end
  end

  assign txReady = txOpen;
  assign txTake = txValid & txOpen;

  always @* begin
    txState_d = txState_q;
    txCount_d = txCount_q;
    if (handshakeLevelSelect) begin
      case (txState_q)
        `UCP_TX_IDLE: begin
          if (txTake && txSoc) begin
            txState_d = `UCP_TX_CELL;
            txCount_d = 6'h01;
          end
        end
        `UCP_TX_CELL: begin
          if (txTake) begin
            if (txCount_q == CELL_BYTES[`UCP_CNT_W-1:0] - 6'h01) begin
              txState_d = `UCP_TX_IDLE;
              txCount_d = {`UCP_CNT_W{1'b0}};
            end else begin
              txCount_d = txCount_q + 6'h01;
            end
          end
        end
        default: begin
          txState_d = `UCP_TX_IDLE;
        end
      endcase
    end else begin
      txState_d = `UCP_TX_IDLE;
      txCount_d = {`UCP_CNT_W{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      txState_q <= `UCP_TX_IDLE;
      txCount_q <= {`UCP_CNT_W{1'b0}};
      txByteBus_q <= 8'h00;
      txCellStart_q <= 1'b0;
      txValidN_q <= 1'b1;
    end else begin
      txState_q <= txState_d;
      txCount_q <= txCount_d;
      // a byte taken in cell mode outside a cell without a start mark is dropped
      if (txTake && (!handshakeLevelSelect || txState_q == `UCP_TX_CELL || txSoc)) begin
        txByteBus_q <= txData;
        txValidN_q <= 1'b0;
        txCellStart_q <= handshakeLevelSelect ? (txState_q == `UCP_TX_IDLE) : txSoc;
      end else begin
        txValidN_q <= 1'b1;
        txCellStart_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // phy control access
  // ---------------------------------------------------------------
  reg ctlState_q;
  reg [`UCP_CNT_W-1:0] ctlCount_q;

  assign ctlBusy = (ctlState_q == `UCP_CTL_BUSY);
  assign phySelectOe = externalPhySelect;
  assign phyCtlDirectionOe = externalPhySelect;

  always @(posedge clk) begin
    if (!rstn) begin
      ctlState_q <= `UCP_CTL_IDLE;
      ctlCount_q <= {`UCP_CNT_W{1'b0}};
      phyCtlDirection_q <= 1'b0;
      phyReadEnableN_q <= 1'b1;
      phySelectN_q <= 1'b1;
      ctlDone_q <= 1'b0;
    end else begin
      ctlDone_q <= 1'b0;
      case (ctlState_q)
        `UCP_CTL_IDLE: begin
          if (ctlReq && externalPhySelect) begin
            ctlState_q <= `UCP_CTL_BUSY;
            ctlCount_q <= {`UCP_CNT_W{1'b0}};
            phyCtlDirection_q <= ctlRead;
            phyReadEnableN_q <= ~ctlRead;
            phySelectN_q <= 1'b0;
          end
        end
        `UCP_CTL_BUSY: begin
          if (ctlCount_q == CTL_ACCESS_CYCLES[`UCP_CNT_W-1:0] - 6'h01) begin
            ctlState_q <= `UCP_CTL_IDLE;
            phyReadEnableN_q <= 1'b1;
            phySelectN_q <= 1'b1;
            ctlDone_q <= 1'b1;
          end else begin
            ctlCount_q <= ctlCount_q + 6'h01;
          end
        end
        default: begin
          ctlState_q <= `UCP_CTL_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // phy interrupt and signal detect
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      phyIrqPending_q <= 1'b0;
      signalDetect_q <= 1'b0;
    end else begin
      // level follows the pin; clearing is done at the phy itself
      phyIrqPending_q <= externalPhySelect & ~irqNSync;
      signalDetect_q <= ~externalPhySelect & detectSync;
    end
  end

  // ---------------------------------------------------------------
  // phy reset stretcher
  // ---------------------------------------------------------------
  reg [`UCP_CNT_W-1:0] rstCount_q;

  always @(posedge clk) begin
    if (!rstn) begin
      rstCount_q <= PHY_RST_CYCLES[`UCP_CNT_W-1:0];
      phyResetOutN_q <= 1'b0;
    end else if (swReset) begin
      rstCount_q <= PHY_RST_CYCLES[`UCP_CNT_W-1:0];
      phyResetOutN_q <= 1'b0;
    end else if (rstCount_q != {`UCP_CNT_W{1'b0}}) begin
      rstCount_q <= rstCount_q - 6'h01;
      phyResetOutN_q <= (rstCount_q == 6'h01);
    end else begin
      phyResetOutN_q <= 1'b1;
    end
  end

endmodule

// ==== ucp_cell_port_properties.sv ====
// Purpose: port checker for ucp_cell_port
// Assumes: one clock domain, rstn synchronous active low
// Notes: bound from the bench top file
module ucp_cell_port_properties (
  input wire clk,
  input wire rstn,
  input wire handshakeLevelSelect,
  input wire externalPhySelect,
  input wire swReset,
  input wire rxReady,
  input wire rxAcceptN_q,
  input wire txValid,
  input wire txReady,
  input wire txValidN_q,
  input wire txCellStart_q,
  input wire ctlReq,
  input wire ctlRead,
  input wire ctlBusy,
  input wire phyCtlDirection_q,
  input wire phyReadEnableN_q,
  input wire phySelectN_q,
  input wire phySelectOe,
  input wire phyIrqN,
  input wire phyIrqPending_q,
  input wire phyResetOutN_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_start;
    ctlReq && !ctlBusy && externalPhySelect;
  endsequence
  sequence s_access;
    !phySelectN_q [*4] ##1 phySelectN_q;
  endsequence
  property p_sel;
    s_start |=> s_access;
  endproperty
  a_sel: assert property (p_sel) else $error("select low time wrong");
  property p_rd;
    s_start ##0 ctlRead |=> !phyReadEnableN_q && phyCtlDirection_q;
  endproperty
  a_rd: assert property (p_rd) else $error("read access levels wrong");
  property p_wr;
    s_start ##0 !ctlRead |=> phyReadEnableN_q && !phyCtlDirection_q;
  endproperty
  a_wr: assert property (p_wr) else $error("write access levels wrong");
  property p_oe;
    phySelectOe == externalPhySelect;
  endproperty
  a_oe: assert property (p_oe) else $error("select pin direction wrong");
  property p_swrst;
    swReset |=> !phyResetOutN_q ##16 !phyResetOutN_q ##1 phyResetOutN_q;
  endproperty
  a_swrst: assert property (p_swrst) else $error("phy reset stretch wrong");
  property p_irq;
    $fell(phyIrqN) && externalPhySelect |-> ##[1:4] phyIrqPending_q;
  endproperty
  a_irq: assert property (p_irq) else $error("phy interrupt not pending");
  property p_rxacc;
    !handshakeLevelSelect |=> rxAcceptN_q == !$past(rxReady);
  endproperty
  a_rxacc: assert property (p_rxacc) else $error("accept does not follow ready");
  property p_txen;
    rstn |=> txValidN_q == !$past(txValid && txReady);
  endproperty
  a_txen: assert property (p_txen) else $error("transmit enable wrong");
  property p_txsoc;
    txCellStart_q |-> !txValidN_q;
  endproperty
  a_txsoc: assert property (p_txsoc) else $error("cell start without byte");
endmodule

// ==== ucp_defines.vh ====
// Purpose: shared constants of the cell port and PHY control block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef UCP_DEFINES_VH
`define UCP_DEFINES_VH

// ---------------------------------------------------------------
// cell framing
// ---------------------------------------------------------------
`define UCP_CELL_BYTES 53
`define UCP_CNT_W 6

// ---------------------------------------------------------------
// pin sampling
// ---------------------------------------------------------------
`define UCP_SYNC_STAGES 2
`define UCP_RX_LAT 3
`define UCP_RX_DRAIN 4

// ---------------------------------------------------------------
// phy control timing
// ---------------------------------------------------------------
`define UCP_PHY_RST_CYCLES 17
`define UCP_CTL_ACCESS_CYCLES 4

// ---------------------------------------------------------------
// state codes
// ---------------------------------------------------------------
`define UCP_RX_IDLE 2'h0
`define UCP_RX_READ 2'h1
`define UCP_RX_DRAIN_ST 2'h2
`define UCP_TX_IDLE 1'h0
`define UCP_TX_CELL 1'h1
`define UCP_CTL_IDLE 1'h0
`define UCP_CTL_BUSY 1'h1

`endif

// ==== ucp_phy_model.sv ====
// Purpose: behavioural PHY on the far side of the cell port
// Assumes: bytes answer one cycle after an accept slot
// Notes: slow stalls octet bytes or drops cell-available
module ucp_phy_model (
  input wire clk,
  input wire rstn,
  input wire cellMode,
  input wire slow,
  input wire room,
  input wire rxAcceptN,
  output reg [7:0] rxByte,
  output reg rxSoc,
  output reg rxEmptyAvail,
  output wire txFullRoom
);
  timeunit 1ns;
  timeprecision 1ns;
  integer n = 0;
  reg tog = 1'b0;
  initial begin
    rxByte = 8'hA5;
    rxSoc = 1'b0;
    rxEmptyAvail = 1'b0;
  end
  assign txFullRoom = room;
  always @(posedge clk) begin
    tog <= ~tog;
    if (!rstn) n <= 0;
    if (rstn && !rxAcceptN && !(slow && !cellMode && tog)) begin
      rxByte <= n[7:0] ^ 8'h5A;
      rxSoc <= (n % 53 == 0);
      rxEmptyAvail <= cellMode ? !slow : 1'b1;
      n <= n + 1;
    end else begin
      // idle bus toggles so a stale byte is never mistaken for data
      rxByte <= ~rxByte;
      rxSoc <= 1'b0;
      rxEmptyAvail <= cellMode ? !slow : 1'b0;
    end
  end
endmodule

// ==== ucp_sync.v ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: clk is the system clock, rstn synchronous active low
// Notes: stage one is read only by stage two
module ucp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rstn,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  always @(posedge clk) begin
    if (!rstn) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule
